/* File: rais_pkg.sv */
// shared constants for the reset sequencer and control-port address select
package rais_pkg;
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned READY_DELAY_MS = 400;
  localparam longint unsigned READY_CYCLES_L = longint'(SYS_CLK_HZ) / 1000 * READY_DELAY_MS;
  localparam logic [31:0] READY_CYCLES = READY_CYCLES_L[31:0];
  localparam logic [6:0] SLAVE_ADDR_LOW = 7'h2c;
  localparam logic [6:0] SLAVE_ADDR_MID = 7'h2d;
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h2e;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [3:0] REG_COUNT = 4'h8;
  typedef enum logic [1:0] {
    RAIS_IDLE = 2'b00,
    RAIS_ADDR = 2'b01,
    RAIS_ACK = 2'b10,
    RAIS_DATA = 2'b11
  } rais_i2c_state_t;
endpackage

/* File: rais_top.sv */
// reset sequencing, strap-selected i2c slave and board overrides
`timescale 1ns/1ps
`default_nettype none
module rais_top
  import rais_pkg::*;
#(
  parameter logic [31:0] READY_COUNT = READY_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [1:0] ADDRESS_STRAP_PIN,
  input wire logic CONTROL_PORT_SERIAL_CLOCK,
  input wire logic CONTROL_PORT_SERIAL_DATA_IN,
  output logic CONTROL_PORT_SERIAL_DATA_OUT,
  output logic CONTROL_PORT_SERIAL_DATA_OE,
  input wire logic ADAPTER_DETECT_SINK_IN,
  input wire logic HOTPLUG_SINK_IN,
  output logic TMDS_MODE,
  output logic SINK_PRESENT,
  output logic DEVICE_READY,
  output logic [7:0] CONFIG_REG0
);
  // input synchronisers
  // scl and sda get a third flop so edges and start/stop can be seen
  logic [1:0] strap_s1_q, strap_s2_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic cad_s1_q, cad_s2_q, hpd_s1_q, hpd_s2_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_s1_q <= STRAP_LOW;
      strap_s2_q <= STRAP_LOW;
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {cad_s1_q, cad_s2_q, hpd_s1_q, hpd_s2_q} <= 4'h0;
    end else begin
      strap_s1_q <= ADDRESS_STRAP_PIN;
      strap_s2_q <= strap_s1_q;
      scl_s1_q <= CONTROL_PORT_SERIAL_CLOCK;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= CONTROL_PORT_SERIAL_DATA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      cad_s1_q <= ADAPTER_DETECT_SINK_IN;
      cad_s2_q <= cad_s1_q;
      hpd_s1_q <= HOTPLUG_SINK_IN;
      hpd_s2_q <= hpd_s1_q;
    end
  end

  // readiness counter; strap latched once at the end of the delay
  // the count stops once ready; only a new reset starts it again
  // the strap goes through its synchroniser, so it must be steady before ready
  // a strap change after ready has no effect until the next reset
  logic [31:0] ready_cnt_q;
  logic ready_q;
  logic [6:0] slave_addr_q;
  wire ready_hit = (ready_cnt_q >= READY_COUNT - 32'h1);
  wire [6:0] strap_addr = (strap_s2_q == STRAP_MID) ? SLAVE_ADDR_MID :
                          (strap_s2_q == STRAP_HIGH) ? SLAVE_ADDR_HIGH :
                          SLAVE_ADDR_LOW;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ready_cnt_q <= 32'h0;
      ready_q <= 1'b0;
      slave_addr_q <= SLAVE_ADDR_LOW;
    end else if (!ready_q) begin
      ready_cnt_q <= ready_cnt_q + 32'h1;
      // last count: raise ready and take the address from the strap
      if (ready_hit) begin
        ready_q <= 1'b1;
        slave_addr_q <= strap_addr;
      end
    end
  end

  // bus conditions
  // start and stop are sda edges while scl stays high
  // both pins pass the same flops, so their relative timing is kept
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_c = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  wire stop_c = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  // i2c slave: byte 0 address, byte 1 register index, then data
  // a read starts at the current index and moves on each time the host acks
  // stop and loss of ready always send the slave back to idle
  rais_i2c_state_t st_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic is_read_q, have_idx_q, drive_q;
  logic [2:0] idx_q;
  logic [7:0] regs_q [0:7];
  wire addr_match = (sh_q[7:1] == slave_addr_q);
  wire [7:0] rd_byte = regs_q[idx_q];

  // read side: next index, its byte and the bit shown after each falling scl
  wire [2:0] idx_next = idx_q + 3'h1;
  wire [7:0] nxt_byte = regs_q[idx_next];
  wire [2:0] rd_bit_sel = 3'h7 - bit_q[2:0];
  wire master_nack = scl_rise && (bit_q == 4'h8) && sda_s2_q;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= RAIS_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      is_read_q <= 1'b0;
      have_idx_q <= 1'b0;
      idx_q <= 3'h0;
      drive_q <= 1'b0;
      for (int i = 0; i < 8; i++) regs_q[i] <= REG_RESET_VALUE;
    end else if (!ready_q || stop_c) begin
      st_q <= RAIS_IDLE;
      drive_q <= 1'b0;
    end else if (start_c) begin
      st_q <= RAIS_ADDR;
      bit_q <= 4'h0;
      have_idx_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      case (st_q)
        RAIS_IDLE: drive_q <= 1'b0;
        RAIS_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            // an address that is not ours drops to idle and never pulls the wire
            if (addr_match) begin
              is_read_q <= sh_q[0];
              drive_q <= 1'b1; // ack
              st_q <= RAIS_ACK;
            end else begin
              st_q <= RAIS_IDLE;
            end
          end
        end
        RAIS_ACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            st_q <= RAIS_DATA;
            if (is_read_q) begin
              sh_q <= rd_byte;
              drive_q <= ~rd_byte[7];
            end else begin
              drive_q <= 1'b0;
            end
          end
        end
        RAIS_DATA: begin
          if (is_read_q) begin
            // bits 7..0 change on falling scl; the ninth clock belongs to the host
            if (master_nack) begin
              st_q <= RAIS_IDLE; // master nack
            end else if (scl_rise) begin
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h9) begin
              idx_q <= idx_next;
              bit_q <= 4'h0;
              sh_q <= nxt_byte;
              drive_q <= ~nxt_byte[7];
            end else if (scl_fall && bit_q == 4'h8) begin
              drive_q <= 1'b0; // release for master ack
            end else if (scl_fall) begin
              drive_q <= ~sh_q[rd_bit_sel];
            end
          end else begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s2_q};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              // the index byte keeps its low three bits: eight registers
              if (!have_idx_q) begin
                idx_q <= sh_q[2:0];
                have_idx_q <= 1'b1;
              end else begin
                regs_q[idx_q] <= sh_q;
                idx_q <= idx_q + 3'h1;
              end
              drive_q <= 1'b1; // ack
              st_q <= RAIS_ACK;
            end
          end
        end
        default: st_q <= RAIS_IDLE;
      endcase
    end
  end

  // sda is open drain: the data output stays low and the enable pulls the wire
  // the enable is gated by ready so no ack leaves before the delay ends
  wire sda_pull = drive_q & ready_q;

  // outputs, all registered
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CONTROL_PORT_SERIAL_DATA_OUT <= 1'b0;
      CONTROL_PORT_SERIAL_DATA_OE <= 1'b0;
      TMDS_MODE <= 1'b0;
      SINK_PRESENT <= 1'b0;
      DEVICE_READY <= 1'b0;
      CONFIG_REG0 <= REG_RESET_VALUE;
    end else begin
      CONTROL_PORT_SERIAL_DATA_OUT <= 1'b0;
      CONTROL_PORT_SERIAL_DATA_OE <= sda_pull;
      TMDS_MODE <= cad_s2_q;
      SINK_PRESENT <= hpd_s2_q;
      DEVICE_READY <= ready_q;
      CONFIG_REG0 <= regs_q[0];
    end
  end
endmodule
`default_nettype wire

/* File: rais_checker.sv */
// port assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rais_checker #(parameter logic [31:0] READY_COUNT = 32'h14) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic ADAPTER_DETECT_SINK_IN,
  input wire logic HOTPLUG_SINK_IN,
  input wire logic CONTROL_PORT_SERIAL_DATA_OUT,
  input wire logic CONTROL_PORT_SERIAL_DATA_OE,
  input wire logic TMDS_MODE,
  input wire logic SINK_PRESENT,
  input wire logic DEVICE_READY,
  input wire logic [7:0] CONFIG_REG0
);
  logic [31:0] cnt_q;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) cnt_q <= 32'h0;
    else if (cnt_q <= READY_COUNT) cnt_q <= cnt_q + 32'h1;
  end
  property p_tmds; $past(RESETN,3) |-> TMDS_MODE == $past(ADAPTER_DETECT_SINK_IN,3); endproperty
  a_tmds: assert property (p_tmds) else $error("tmds lag");
  property p_sink; $past(RESETN,3) |-> SINK_PRESENT == $past(HOTPLUG_SINK_IN,3); endproperty
  a_sink: assert property (p_sink) else $error("sink lag");
  property p_noack; !DEVICE_READY |-> !CONTROL_PORT_SERIAL_DATA_OE; endproperty
  a_noack: assert property (p_noack) else $error("early ack");
  property p_dflt; !DEVICE_READY |-> CONFIG_REG0 == 8'h00; endproperty
  a_dflt: assert property (p_dflt) else $error("reg not default");
  property p_rdy; DEVICE_READY == (cnt_q > READY_COUNT); endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_od; !CONTROL_PORT_SERIAL_DATA_OUT; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  c_ack: cover property (CONTROL_PORT_SERIAL_DATA_OE);
  c_rdy: cover property ($rose(DEVICE_READY));
  c_ovr: cover property (TMDS_MODE && SINK_PRESENT);
endmodule
bind rais_top rais_checker #(.READY_COUNT(READY_COUNT)) u_chk (.*);
`default_nettype wire

/* File: rais_host.sv */
// board i2c host that bit-bangs the control port
`timescale 1ns/1ps
`default_nettype none
module rais_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic ph(input logic c, input logic d);
    @(posedge clk) scl <= c;
    sda_low <= d;
    repeat (7) @(posedge clk);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    w = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, sda_low);
      ph(1'b0, !w[i]);
      ph(1'b1, !w[i]);
    end
    ack = !sda;
  endtask
  task automatic get(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, sda_low);
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      b[i] = sda;
    end
    ph(1'b0, sda_low);
    ph(1'b0, !nack);
    ph(1'b1, !nack);
  endtask
  task automatic stop;
    ph(1'b0, sda_low);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
endmodule
`default_nettype wire

/* File: reset_and_i2c_address_select_tb.sv */
// self-checking bench for the reset sequencer and address select
`timescale 1ns/1ps
`default_nettype none
module reset_and_i2c_address_select_tb;
  import rais_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap = 2'h0;
  logic ad = 1'b0;
  logic hp = 1'b0;
  logic scl, sda_low, oe, tmds, sink, rdy, ack, sdo;
  logic [7:0] reg0, rd;
  int error_cnt = 0;
  int checked = 0;
  wire logic sda = !(sda_low | oe);
  rais_top #(.READY_COUNT(32'h14)) DUT (.SYS_CLK(clk), .RESETN(rst_n), .ADDRESS_STRAP_PIN(strap),
    .CONTROL_PORT_SERIAL_CLOCK(scl), .CONTROL_PORT_SERIAL_DATA_IN(sda),
    .CONTROL_PORT_SERIAL_DATA_OUT(sdo), .CONTROL_PORT_SERIAL_DATA_OE(oe),
    .ADAPTER_DETECT_SINK_IN(ad), .HOTPLUG_SINK_IN(hp), .TMDS_MODE(tmds),
    .SINK_PRESENT(sink), .DEVICE_READY(rdy), .CONFIG_REG0(reg0));
  rais_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset(input logic [1:0] s);
    @(posedge clk) rst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge clk);
    chk({4'h0, rdy, oe, tmds, sink}, 8'h00);
    rst_n <= 1'b1;
    for (int i = 0; i < 100 && rdy !== 1'b1; i++) @(posedge clk);
    chk({7'h0, rdy}, 8'h01);
  endtask
  task automatic t_addr(input logic [1:0] s, input logic [6:0] a);
    t_reset(s);
    chk(reg0, 8'h00);
    host.ph(1'b1, 1'b1);
    host.put({a, 1'b0}, ack);
    chk({7'h0, ack}, 8'h01);
    host.put(8'h00, ack);
    host.put({6'h2a, s}, ack);
    host.stop;
    chk(reg0, {6'h2a, s});
    host.ph(1'b1, 1'b1);
    host.put({a ^ 7'h01, 1'b1}, ack);
    chk({7'h0, ack}, 8'h00);
    host.stop;
  endtask
  task automatic t_read;
    host.ph(1'b1, 1'b1);
    host.put({SLAVE_ADDR_LOW, 1'b0}, ack);
    host.put(8'h01, ack);
    host.put(8'h5a, ack);
    host.put(8'ha5, ack);
    chk({7'h0, ack}, 8'h01);
    host.stop;
    host.ph(1'b1, 1'b1);
    host.put({SLAVE_ADDR_LOW, 1'b0}, ack);
    host.put(8'h01, ack);
    host.stop;
    host.ph(1'b1, 1'b1);
    host.put({SLAVE_ADDR_LOW, 1'b1}, ack);
    chk({7'h0, ack}, 8'h01);
    host.get(1'b0, rd);
    chk(rd, 8'h5a);
    host.get(1'b1, rd);
    chk(rd, 8'ha5);
    host.stop;
    chk({7'h0, sdo}, 8'h00);
  endtask
  task automatic t_ovr;
    for (int v = 0; v < 4; v++) begin
      @(posedge clk) {ad, hp} <= 2'(v);
      repeat (4) @(posedge clk);
      chk({6'h0, tmds, sink}, 8'(v));
    end
  endtask
  initial begin
    t_addr(2'h0, SLAVE_ADDR_LOW);
    t_addr(2'h1, SLAVE_ADDR_MID);
    t_addr(2'h2, SLAVE_ADDR_HIGH);
    t_addr(2'h3, SLAVE_ADDR_LOW);
    t_read;
    t_ovr;
    complete_run;
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
